// ===== logic/quad_pot_map.svh
// encodings, reset values and timing constants of the quad pot slave
`ifndef QUAD_POT_MAP_SVH
`define QUAD_POT_MAP_SVH

// =====================================
// instruction codes (upper command nibble)
`define OP_READ_WIPER         4'h9
`define OP_WRITE_WIPER        4'hA
`define OP_READ_STORED        4'hB
`define OP_WRITE_STORED       4'hC
`define OP_XFR_STORED_WIPER   4'hD
`define OP_XFR_WIPER_STORED   4'hE
`define OP_GXFR_STORED_WIPER  4'h1
`define OP_GXFR_WIPER_STORED  4'h8

// =====================================
// bit counter positions
`define FIRST_BIT       4'h1
`define ACK_BIT         4'h8
`define IDLE_CNT        4'h0

// =====================================
// reset values and timing
`define POWER_ON_SETTING 6'h20
`define NV_WRITE_TIME_US 10000
`define CORE_CLK_MHZ     20

`endif

// ===== logic/quad_pot_pkg.sv
// types shared by the quad pot serial slave
`default_nettype none
package quad_pot_pkg;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_ADDR  = 3'b001,
    LS_CMD   = 3'b010,
    LS_WDATA = 3'b011,
    LS_RDATA = 3'b100
  } link_state_type;

  typedef struct packed {
    logic [3:0] instr;
    logic [1:0] register_select;
    logic [1:0] channel_select;
  } cmd_type;

  typedef struct packed {
    logic       global;
    logic       from_wiper;
    logic [1:0] register_select;
    logic [1:0] channel_select;
    logic [5:0] data;
  } nv_req_type;

endpackage
`default_nettype wire

// ===== logic/quad_pot_serial_slave.sv
// two-wire slave, wiper and stored-setting registers of a quad pot
//
// Notes on behaviour
// - data line is only pulled low or released, never driven high
// - low address nibble must equal the strap inputs before talking
// - write-protect low refuses every stored-setting write
// - transmitter changes data only while clock is low
// - start is data falling with clock high; ignore all until one
// - ninth clock after eight bits carries the receiver's low ack
// - ack address, command byte and a following data byte
// - four channels, each one wiper register and four stored settings
// - power-up loads POWER_ON_SETTING into each wiper and each stored setting
// - six wiper bits select exactly one of sixty-four taps
// - 63 segments per array, taps at both ends and between each
// - wiper updated by host write or transfer from a stored setting
// - address ack only when all four strap bits compare equal
// - no address ack while stored write runs after a stop
// - command: instruction nibble, register select, channel select
`include "quad_pot_map.svh"
`default_nettype none

module quad_pot_serial_slave #(
  parameter int unsigned WIPER_BITS      = 6,
  parameter logic [3:0]  DEVICE_TYPE_ID  = 4'hA, // arbitrary value
  parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_TIME_US * `CORE_CLK_MHZ,
  localparam int unsigned TAPS           = 2 ** WIPER_BITS
) (
  // core clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  // two-wire link
  input  wire logic                       scl,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_n,
  // straps and protection
  input  wire logic [3:0]                 addr_strap_inputs,
  input  wire logic                       write_protect_n,
  // potentiometer side
  output logic [3:0][TAPS-1:0]            tap_select,
  output logic [3:0][WIPER_BITS-1:0]      wiper_position,
  output logic                            nv_write_busy
);
  import quad_pot_pkg::*;

  localparam int unsigned CNT_W = $clog2(NV_WRITE_CYCLES + 1);

  // =====================================
  // reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // =====================================
  // start and stop detection
  // clocked by the data line itself: the link clock is high and still here
  logic start_tog_ff;
  logic stop_tog_ff;

  always_ff @(negedge sda_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      start_tog_ff <= 1'b0;
    end else if (scl) begin
      start_tog_ff <= ~start_tog_ff;
    end
  end

  always_ff @(posedge sda_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      stop_tog_ff <= 1'b0;
    end else if (scl) begin
      stop_tog_ff <= ~stop_tog_ff;
    end
  end

  // =====================================
  // link-side registers
  link_state_type        state_ff;
  link_state_type        nxt_state;
  logic [3:0]            bit_cnt_ff;
  logic [3:0]            nxt_bit_cnt;
  logic [7:0]            shift_ff;
  logic [7:0]            nxt_shift;
  cmd_type               cmd_ff;
  cmd_type               nxt_cmd;
  nv_req_type            req_ff;
  nv_req_type            nxt_req;
  logic                  req_tog_ff;
  logic                  nxt_req_tog;
  logic                  start_seen_ff;
  logic                  stop_seen_ff;
  logic [3:0]            strap_meta_ff;
  logic [3:0]            strap_ff;
  logic                  busy_meta_ff;
  logic                  busy_link_ff;
  logic                  sda_drive_ff;
  logic [WIPER_BITS-1:0] wiper_ff [4];
  logic [TAPS-1:0]       tap_ff [4];
  logic [WIPER_BITS-1:0] stored_ff [16];
  logic                  busy_ff;

  // =====================================
  // link decode
  // toggles are settled long before the clock rises after a start or stop
  cmd_type rx_cmd;
  wire start_pend = start_tog_ff != start_seen_ff;
  wire stop_pend  = stop_tog_ff != stop_seen_ff;
  wire ack_clock  = bit_cnt_ff == `ACK_BIT;
  wire link_go    = !start_pend && !stop_pend && ack_clock;
  wire type_match = shift_ff[7:4] == DEVICE_TYPE_ID;
  wire strap_match = shift_ff[3:0] == strap_ff;
  wire addr_ack   = type_match && strap_match && !busy_link_ff;
  wire cmd_ack    = link_go && state_ff == LS_CMD;
  wire data_ack   = link_go && state_ff == LS_WDATA;
  wire want_ack   = ack_clock && ((state_ff == LS_ADDR && addr_ack) ||
                    state_ff == LS_CMD || state_ff == LS_WDATA);
  wire read_low   = state_ff == LS_RDATA && bit_cnt_ff < `ACK_BIT && !shift_ff[7];
  wire drive_low  = !start_pend && !stop_pend && (want_ack || read_low);
  wire [3:0] rd_idx = {rx_cmd.channel_select, rx_cmd.register_select};
  assign rx_cmd = cmd_type'(shift_ff);

  // =====================================
  // link next state
  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff + 4'h1;
    nxt_shift   = {shift_ff[6:0], sda_i};
    nxt_cmd     = cmd_ff;
    nxt_req     = req_ff;
    nxt_req_tog = req_tog_ff;
    if (start_pend) begin
      nxt_state   = LS_ADDR;
      nxt_bit_cnt = `FIRST_BIT;
    end else if (stop_pend) begin
      nxt_state   = LS_IDLE;
      nxt_bit_cnt = `IDLE_CNT;
    end else if (ack_clock) begin
      nxt_bit_cnt = `IDLE_CNT;
      case (state_ff)
        LS_ADDR: begin
          nxt_state = addr_ack ? LS_CMD : LS_IDLE;
        end
        LS_CMD: begin
          nxt_cmd   = rx_cmd;
          nxt_state = LS_IDLE;
          case (rx_cmd.instr)
            `OP_READ_WIPER: begin
              nxt_state = LS_RDATA;
              nxt_shift = 8'(wiper_ff[rx_cmd.channel_select]);
            end
            `OP_READ_STORED: begin
              nxt_state = LS_RDATA;
              nxt_shift = 8'(stored_ff[rd_idx]);
            end
            `OP_WRITE_WIPER, `OP_WRITE_STORED: begin
              nxt_state = LS_WDATA;
            end
            `OP_XFR_WIPER_STORED, `OP_GXFR_WIPER_STORED: begin
              nxt_req.global          = rx_cmd.instr == `OP_GXFR_WIPER_STORED;
              nxt_req.from_wiper      = 1'b1;
              nxt_req.register_select = rx_cmd.register_select;
              nxt_req.channel_select  = rx_cmd.channel_select;
              nxt_req_tog             = ~req_tog_ff;
            end
            default: begin
              nxt_state = LS_IDLE;
            end
          endcase
        end
        LS_WDATA: begin
          nxt_state = LS_IDLE;
          if (cmd_ff.instr == `OP_WRITE_STORED) begin
            nxt_req.global          = 1'b0;
            nxt_req.from_wiper      = 1'b0;
            nxt_req.register_select = cmd_ff.register_select;
            nxt_req.channel_select  = cmd_ff.channel_select;
            nxt_req.data            = shift_ff[5:0];
            nxt_req_tog             = ~req_tog_ff;
          end
        end
        default: begin
          nxt_state = LS_IDLE;
        end
      endcase
    end else if (state_ff == LS_IDLE) begin
      nxt_bit_cnt = bit_cnt_ff;
    end
  end

  // =====================================
  // link flops
  always_ff @(posedge scl or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff      <= LS_IDLE;
      bit_cnt_ff    <= `IDLE_CNT;
      shift_ff      <= 8'h00;
      cmd_ff        <= cmd_type'(8'h00);
      req_ff        <= nv_req_type'(12'h000);
      req_tog_ff    <= 1'b0;
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      bit_cnt_ff    <= nxt_bit_cnt;
      shift_ff      <= nxt_shift;
      cmd_ff        <= nxt_cmd;
      req_ff        <= nxt_req;
      req_tog_ff    <= nxt_req_tog;
      start_seen_ff <= start_tog_ff;
      stop_seen_ff  <= stop_tog_ff;
    end
  end

  always_ff @(posedge scl or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      strap_meta_ff <= 4'h0;
      strap_ff      <= 4'h0;
      busy_meta_ff  <= 1'b0;
      busy_link_ff  <= 1'b0;
    end else begin
      strap_meta_ff <= addr_strap_inputs;
      strap_ff      <= strap_meta_ff;
      busy_meta_ff  <= busy_ff;
      busy_link_ff  <= busy_meta_ff;
    end
  end

  // data changes only on the falling clock
  always_ff @(negedge scl or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sda_drive_ff <= 1'b0;
    end else begin
      sda_drive_ff <= drive_low;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = !sda_drive_ff;

  // =====================================
  // wiper registers and tap decode, one per channel
  for (genvar c = 0; c < 4; c++) begin : g_chan
    localparam logic [1:0] CH = 2'(c);
    logic [WIPER_BITS-1:0] nxt_wiper;
    wire wr_hit  = data_ack && cmd_ff.instr == `OP_WRITE_WIPER && cmd_ff.channel_select == CH;
    wire xfr_hit = cmd_ack && ((rx_cmd.instr == `OP_XFR_STORED_WIPER && rx_cmd.channel_select == CH) ||
                   rx_cmd.instr == `OP_GXFR_STORED_WIPER);
    assign nxt_wiper = wr_hit  ? shift_ff[WIPER_BITS-1:0] :
                       xfr_hit ? stored_ff[{CH, rx_cmd.register_select}] :
                       wiper_ff[c];

    always_ff @(posedge scl or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
        wiper_ff[c] <= `POWER_ON_SETTING;
        tap_ff[c]   <= TAPS'(1) << `POWER_ON_SETTING;
      end else begin
        wiper_ff[c] <= nxt_wiper;
        tap_ff[c]   <= TAPS'(1) << nxt_wiper;
      end
    end

    assign tap_select[c]     = tap_ff[c];
    assign wiper_position[c] = wiper_ff[c];

    AST_TAP_ONEHOT: assert property (@(posedge scl) disable iff (!rst_sync_ff)
      $onehot(tap_ff[c]) && tap_ff[c] == (TAPS'(1) << wiper_ff[c]))
      else $error("tap select not one-hot or not matching wiper");
  end

  // =====================================
  // core side: stored-setting writes
  logic             wp_meta_ff;
  logic             wp_ff;
  logic             stop_meta_ff;
  logic             stop_sync_ff;
  logic             stop_last_ff;
  logic             req_meta_ff;
  logic             req_sync_ff;
  logic             done_tog_ff;
  logic [CNT_W-1:0] nv_cnt_ff;

  // request fields are quiet once the link clock has stopped for the stop
  wire stop_evt = stop_sync_ff != stop_last_ff;
  wire commit   = stop_evt && req_sync_ff != done_tog_ff && !busy_ff;
  wire nv_write = commit && wp_ff;
  wire cnt_end  = nv_cnt_ff == CNT_W'(NV_WRITE_CYCLES - 1);

  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      wp_meta_ff   <= 1'b0;
      wp_ff        <= 1'b0;
      stop_meta_ff <= 1'b0;
      stop_sync_ff <= 1'b0;
      stop_last_ff <= 1'b0;
      req_meta_ff  <= 1'b0;
      req_sync_ff  <= 1'b0;
    end else begin
      wp_meta_ff   <= write_protect_n;
      wp_ff        <= wp_meta_ff;
      stop_meta_ff <= stop_tog_ff;
      stop_sync_ff <= stop_meta_ff;
      stop_last_ff <= stop_sync_ff;
      req_meta_ff  <= req_tog_ff;
      req_sync_ff  <= req_meta_ff;
    end
  end

  // a protected request is consumed, so it cannot fire on a later stop
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      done_tog_ff <= 1'b0;
      busy_ff     <= 1'b0;
      nv_cnt_ff   <= '0;
    end else begin
      done_tog_ff <= commit ? req_sync_ff : done_tog_ff;
      busy_ff     <= nv_write || (busy_ff && !cnt_end);
      nv_cnt_ff   <= busy_ff ? nv_cnt_ff + CNT_W'(1) : '0;
    end
  end

  assign nv_write_busy = busy_ff;

  for (genvar e = 0; e < 16; e++) begin : g_store
    localparam logic [1:0] CH = 2'(e / 4);
    localparam logic [1:0] RS = 2'(e % 4);
    wire hit = nv_write && req_ff.register_select == RS &&
               (req_ff.global || req_ff.channel_select == CH);
    wire [WIPER_BITS-1:0] value = req_ff.from_wiper ? wiper_ff[e / 4] : req_ff.data;

    always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
        stored_ff[e] <= `POWER_ON_SETTING;
      end else if (hit) begin
        stored_ff[e] <= value;
      end
    end
  end

  // =====================================
  // checks
  AST_ADDR_NAK_MISMATCH: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (state_ff == LS_ADDR && ack_clock && !start_pend && !strap_match) |-> sda_oe_n)
    else $error("address acked despite strap mismatch");

  AST_ADDR_ACK: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (state_ff == LS_ADDR && ack_clock && !start_pend && !stop_pend && addr_ack) |-> !sda_oe_n)
    else $error("matching address not acked");

  AST_BUSY_NAK: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (state_ff == LS_ADDR && ack_clock && busy_link_ff) |-> sda_oe_n)
    else $error("address acked during stored write");

  AST_MISMATCH_IDLE: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (state_ff == LS_ADDR && link_go && !addr_ack) |=> state_ff == LS_IDLE && sda_oe_n)
    else $error("mismatched address did not return to idle");

  AST_START_RESTART: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    start_pend |=> state_ff == LS_ADDR && bit_cnt_ff == `FIRST_BIT)
    else $error("start did not restart address phase");

  AST_STOP_IDLE: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (stop_pend && !start_pend) |=> state_ff == LS_IDLE && bit_cnt_ff == `IDLE_CNT)
    else $error("stop did not abandon the command");

  AST_ACK_ONLY_NINTH: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (!sda_oe_n && state_ff != LS_RDATA) |-> ack_clock)
    else $error("data line pulled outside an ack clock");

  AST_WRITE_WIPER: assert property (@(posedge scl) disable iff (!rst_sync_ff)
    (data_ack && cmd_ff.instr == `OP_WRITE_WIPER)
    |=> wiper_ff[$past(cmd_ff.channel_select)] == $past(shift_ff[WIPER_BITS-1:0]))
    else $error("wiper write not applied");

  AST_WP_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    (commit && !wp_ff) |=> !busy_ff ##1 !busy_ff)
    else $error("protected stored write started");

  AST_NV_BUSY_SPAN: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    nv_write |=> busy_ff && nv_cnt_ff == '0 ##1 busy_ff)
    else $error("stored write did not hold busy");

  AST_SDA_LOW_ONLY: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    !sda_oe_n |-> sda_o == 1'b0)
    else $error("data line driven high");

endmodule // quad_pot_serial_slave
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the quad pot serial slave
`include "quad_pot_map.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 10ps;

  localparam logic [3:0] TYPE_ID = 4'h3; // arbitrary value
  localparam logic [3:0] STRAPS  = 4'h6;
  localparam logic [7:0] ADDR    = {TYPE_ID, STRAPS};
  localparam int         NV_CYC  = 20;

  logic             core_clk;
  logic             reset_n;
  logic             write_protect_n;
  logic [3:0]       addr_strap_inputs;
  logic             scl;
  logic             sda_out;
  logic             sda_o;
  logic             sda_oe_n;
  logic [3:0][63:0] tap_select;
  logic [3:0][5:0]  wiper_position;
  logic             nv_write_busy;
  int               error_cnt = 0;
  int               n_tests = 0;
  // pull-up: low only when someone pulls
  wire logic        sda_line = sda_out & (sda_oe_n | sda_o);

  two_wire_master master (.scl(scl), .sda_out(sda_out), .sda_line(sda_line));

  quad_pot_serial_slave #(.DEVICE_TYPE_ID(TYPE_ID), .NV_WRITE_CYCLES(NV_CYC)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_strap_inputs(addr_strap_inputs), .write_protect_n(write_protect_n),
    .tap_select(tap_select), .wiper_position(wiper_position), .nv_write_busy(nv_write_busy));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // =====================================
  // shared helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic open_frame(input logic [7:0] a, input logic exp_ack);
    logic ack;
    master.begin_frame();
    master.send_byte(a, ack);
    check(64'(ack), 64'(exp_ack));
  endtask

  task automatic put(input logic [7:0] b);
    logic ack;
    master.send_byte(b, ack);
    check(64'(ack), 64'h1);
  endtask

  // stop, then let the core see it
  task automatic close_frame;
    master.end_frame();
    repeat (6) @(posedge core_clk);
    // look away from the edge that updates the outputs
    @(negedge core_clk);
  endtask

  task automatic command(input logic [7:0] cmd, input logic with_data, input logic [7:0] data);
    open_frame(ADDR, 1'b1);
    put(cmd);
    if (with_data) begin
      put(data);
    end
    close_frame();
  endtask

  task automatic read_reg(input logic [7:0] cmd, input logic [5:0] exp);
    logic [7:0] b;
    open_frame(ADDR, 1'b1);
    put(cmd);
    master.recv_byte(b);
    close_frame();
    check(64'(b), {58'h0, exp});
  endtask

  task automatic check_pot(input int ch, input logic [5:0] v);
    check(64'(wiper_position[ch]), 64'(v));
    check(tap_select[ch], 64'h1 << v);
  endtask

  task automatic nv_wait;
    repeat (NV_CYC + 10) @(posedge core_clk);
  endtask

  // =====================================
  // scenarios
  task automatic test_power_up;
    for (int ch = 0; ch < 4; ch++) begin
      check_pot(ch, `POWER_ON_SETTING);
    end
    check(64'(sda_oe_n), 64'h1);
    check(64'(nv_write_busy), 64'h0);
    $display("power-up test done");
  endtask

  task automatic test_write_wiper;
    logic [5:0] val [4] = '{6'h00, 6'h3F, 6'h15, 6'h2A};
    // top data bits set on purpose: they must be dropped
    for (int ch = 0; ch < 4; ch++) begin
      command({`OP_WRITE_WIPER, 2'b00, 2'(ch)}, 1'b1, {2'b11, val[ch]});
    end
    for (int ch = 0; ch < 4; ch++) begin
      check_pot(ch, val[ch]);
      read_reg({`OP_READ_WIPER, 2'b00, 2'(ch)}, val[ch]);
    end
    $display("wiper write test done");
  endtask

  task automatic test_addr_refused;
    logic ack;
    open_frame({TYPE_ID, STRAPS ^ 4'h1}, 1'b0);
    master.send_byte({`OP_WRITE_WIPER, 4'h0}, ack);
    check(64'(ack), 64'h0);
    master.send_byte(8'h07, ack);
    close_frame();
    open_frame({~TYPE_ID, STRAPS}, 1'b0);
    close_frame();
    check_pot(0, 6'h00);
    @(posedge core_clk);
    addr_strap_inputs <= 4'h9;
    repeat (2) @(posedge core_clk);
    open_frame({TYPE_ID, 4'h9}, 1'b1);
    close_frame();
    @(posedge core_clk);
    addr_strap_inputs <= STRAPS;
    $display("address refusal test done");
  endtask

  task automatic test_stop_abort;
    open_frame(ADDR, 1'b1);
    put({`OP_WRITE_WIPER, 2'b00, 2'd2});
    close_frame();
    check_pot(2, 6'h15);
    command({`OP_WRITE_WIPER, 2'b00, 2'd2}, 1'b1, 8'h07);
    check_pot(2, 6'h07);
    $display("stop abort test done");
  endtask

  task automatic test_stored_write;
    command({`OP_WRITE_STORED, 2'd2, 2'd3}, 1'b1, 8'h0B);
    check(64'(nv_write_busy), 64'h1);
    open_frame(ADDR, 1'b0);
    close_frame();
    nv_wait();
    check(64'(nv_write_busy), 64'h0);
    open_frame(ADDR, 1'b1);
    close_frame();
    read_reg({`OP_READ_STORED, 2'd2, 2'd3}, 6'h0B);
    command({`OP_XFR_STORED_WIPER, 2'd2, 2'd3}, 1'b0, 8'h00);
    check_pot(3, 6'h0B);
    $display("stored write test done");
  endtask

  task automatic test_transfers;
    command({`OP_XFR_WIPER_STORED, 2'd3, 2'd1}, 1'b0, 8'h00);
    nv_wait();
    read_reg({`OP_READ_STORED, 2'd3, 2'd1}, 6'h3F);
    command({`OP_GXFR_STORED_WIPER, 2'd0, 2'd0}, 1'b0, 8'h00);
    for (int ch = 0; ch < 4; ch++) begin
      check_pot(ch, `POWER_ON_SETTING);
    end
    // a distinct wiper so the global store is seen to move data
    command({`OP_WRITE_WIPER, 2'b00, 2'd2}, 1'b1, 8'h2D);
    command({`OP_GXFR_WIPER_STORED, 2'd1, 2'd0}, 1'b0, 8'h00);
    nv_wait();
    read_reg({`OP_READ_STORED, 2'd1, 2'd2}, 6'h2D);
    read_reg({`OP_READ_STORED, 2'd1, 2'd1}, `POWER_ON_SETTING);
    $display("transfer test done");
  endtask

  task automatic test_write_protect;
    @(posedge core_clk);
    write_protect_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    command({`OP_WRITE_STORED, 2'd1, 2'd0}, 1'b1, 8'h11);
    check(64'(nv_write_busy), 64'h0);
    nv_wait();
    read_reg({`OP_READ_STORED, 2'd1, 2'd0}, `POWER_ON_SETTING);
    @(posedge core_clk);
    write_protect_n <= 1'b1;
    $display("write protect test done");
  endtask

  // =====================================
  // main sequence and watchdog
  initial begin
    reset_n           = 1'b0;
    write_protect_n   = 1'b1;
    addr_strap_inputs = STRAPS;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    test_power_up();
    test_write_wiper();
    test_addr_refused();
    test_stop_abort();
    test_stored_write();
    test_transfers();
    test_write_protect();
    final_report();
  end

  // the whole sequence needs well under 60 us
  initial begin
    #100000;
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
endmodule // tb

`default_nettype wire

// ===== sim/two_wire_master.sv
// bus master model that drives the two-wire link of the quad pot slave
`default_nettype none

module two_wire_master (
  // link
  output logic      scl,
  output logic      sda_out,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 10ps;

  localparam real QTR = 3.75;

  // =====================================
  // idle: clock parked high, data released
  initial begin
    scl     = 1'b1;
    sda_out = 1'b1;
  end

  // =====================================
  // framing
  task automatic begin_frame;
    #QTR;
    sda_out = 1'b0;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask

  task automatic end_frame;
    sda_out = 1'b0;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_out = 1'b1;
    #QTR;
  endtask

  // =====================================
  // bits and bytes
  // data moves only a quarter period after the clock fell
  task automatic clock_bit(input logic b, output logic s);
    sda_out = b;
    #QTR;
    scl = 1'b1;
    #QTR;
    s = sda_line;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  // reads eight bits, then leaves the ninth clock unacknowledged
  task automatic recv_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(1'b1, s);
  endtask
endmodule // two_wire_master

`default_nettype wire
